/* rs485_pkg.sv */
// Purpose: Shared constants for the RS-485 direction and address logic.
// Assumes: 8-bit registers on a 4-bit register index.
// Notes: All offsets, field positions and the 8-bit register and pin reset values live here.
package rs485_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Register indices on the plain register port.
  localparam logic [3:0] OFS_MODEM_CTRL = 4'h0;
  localparam logic [3:0] OFS_FEATURE_CTRL = 4'h1;
  localparam logic [3:0] OFS_RS485_CTRL = 4'h2;
  localparam logic [3:0] OFS_ENH_FEATURE = 4'h3;
  localparam logic [3:0] OFS_MATCH_CHAR = 4'h4;
  localparam logic [3:0] OFS_LINE_CTRL = 4'h5;
  localparam logic [3:0] OFS_INT_ENABLE = 4'h6;
  localparam logic [3:0] OFS_LINE_STATUS = 4'h7;
  localparam logic [3:0] OFS_RX_CTRL = 4'h8;
  localparam logic [3:0] OFS_INT_STATUS = 4'h9;
  localparam logic [3:0] OFS_INT_CLEAR = 4'hA;

  // Field positions.
  localparam int BIT_MODEM_RTS = 1;
  localparam int BIT_AUTO_DIR = 5;
  localparam int BIT_MULTIDROP = 0;
  localparam int BIT_RTS_INVERT = 5;
  localparam int BIT_SPECIAL_CHAR = 5;
  localparam int BIT_RX_ENABLE = 0;
  localparam int BIT_DATA_READY = 0;
  localparam int BIT_PARITY_ERR = 2;
  localparam int BIT_EV_RX_DATA = 0;
  localparam int BIT_EV_TX_DONE = 1;
  localparam int BIT_EV_LINE_STATUS = 2;

  // Reset values.
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic RST_RTS_PIN = 1'b1;
endpackage

/* rx_filter_if.sv */
// Purpose: Carries a received character and the filter decision.
// Assumes: One character per valid cycle.
// Notes: The core drives the character and mode, the filter decides.
`timescale 1ns/1ps
interface rx_filter_if;
  logic multidrop;
  logic special;
  logic rx_en;
  logic [7:0] match;
  logic valid;
  logic [7:0] data;
  logic parity;
  logic perr_in;
  logic push;
  logic push_perr;
  logic en_set;
  logic en_clr;

  modport filter (
    input multidrop, special, rx_en, match, valid, data, parity, perr_in,
    output push, push_perr, en_set, en_clr
  );
  modport core (
    output multidrop, special, rx_en, match, valid, data, parity, perr_in,
    input push, push_perr, en_set, en_clr
  );
endinterface

/* rx_addr_filter.sv */
// Purpose: Decides whether a received character enters the receive FIFO.
// Assumes: The ninth bit marks an address character when it is one.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module rx_addr_filter
  import rs485_pkg::*;
(
  rx_filter_if.filter f
);
  wire is_addr;
  wire is_match;
  wire normal_mode;
  wire auto_mode;

  assign is_addr = f.parity;
  assign is_match = is_addr && (f.data == f.match);
  assign normal_mode = f.multidrop && !f.special;
  assign auto_mode = f.multidrop && f.special;

  // Outside multidrop every character passes with its own parity result.
  assign f.push = f.valid && (!f.multidrop
    || (normal_mode && (is_addr || f.rx_en))
    || (auto_mode && (is_match || (!is_addr && f.rx_en))));
  assign f.push_perr = !f.multidrop ? f.perr_in
    : (normal_mode ? is_addr : is_match);
  assign f.en_set = f.valid && auto_mode && is_match;
  assign f.en_clr = f.valid && auto_mode && is_addr && !is_match;
endmodule // rx_addr_filter

/* rs485_ctrl.sv */
// Purpose: RS-485 direction control and 9-bit address detection.
// Assumes: Serial engine reports characters and transmit status per cycle.
// Notes: Registers sit on a plain port with read data one cycle later.
//
// What this block does
// - Pin is the inverse of modem bit 1, or follows flow logic; auto-direction bit overrides.
// - Auto-direction pin goes high on transmit write, low after last bit.
// - Inverted polarity: pin low while sending, high after last bit.
// - Multidrop bit enables 9-bit mode; ninth bit one marks address.
// - Disabled receiver drops data, stores address with parity error.
// - Enabled receiver takes data; later address again flags parity error.
// - Auto detection discards data and non-matching addresses when off.
// - Matching address enables receiver, stores it, raises line status.
// - Non-matching address in auto mode disables receiver and is dropped.
// - Matching address while enabled is stored with parity error flag.
// - Interrupt enable bit 2 gates the line status interrupt.
`timescale 1ns/1ps
module rs485_ctrl
  import rs485_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  input wire logic HW_FLOW_EN,
  input wire logic FLOW_RTS_PIN,
  input wire logic TX_LOAD,
  input wire logic TX_IDLE,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_PARITY,
  input wire logic RX_PERR,
  output logic RTS_PIN,
  output logic FIFO_PUSH,
  output logic [7:0] FIFO_DATA,
  output logic FIFO_PERR,
  output logic IRQ
);
  typedef enum logic [1:0]
  {
    DIR_IDLE = 2'b00,
    DIR_SEND = 2'b01
  } dir_state_t;

  logic [7:0] modem_control_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] rs485_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] second_match_char_reg;
  logic [7:0] line_control_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] line_status_reg;
  logic [7:0] int_status_reg;
  logic rx_en_reg;
  dir_state_t dir_reg;
  dir_state_t dir_next;
  logic [7:0] line_status_next;
  logic [7:0] int_status_next;
  logic rx_en_next;
  logic rts_next;
  logic [7:0] rdata_next;

  rx_filter_if fif ();

  function automatic logic wr_hit(input logic [3:0] ofs);
    wr_hit = REG_WR && (REG_ADDR == ofs);
  endfunction

  function automatic logic rd_hit(input logic [3:0] ofs);
    rd_hit = REG_RD && (REG_ADDR == ofs);
  endfunction

  wire auto_dir = feature_control_reg[BIT_AUTO_DIR];
  wire rts_invert = rs485_control_reg[BIT_RTS_INVERT];
  wire multidrop = rs485_control_reg[BIT_MULTIDROP];
  wire special = enhanced_feature_reg[BIT_SPECIAL_CHAR];
  wire sending = (dir_next == DIR_SEND);
  wire tx_done = (dir_reg == DIR_SEND) && (dir_next == DIR_IDLE);
  wire [7:0] irq_src = int_status_next & interrupt_enable_reg;

  assign fif.multidrop = multidrop;
  assign fif.special = special;
  assign fif.rx_en = rx_en_reg;
  assign fif.match = second_match_char_reg;
  assign fif.valid = RX_VALID;
  assign fif.data = RX_DATA;
  assign fif.parity = RX_PARITY;
  assign fif.perr_in = RX_PERR;

  rx_addr_filter u_filter (
    .f(fif)
  );

  // Direction tracks a pending transmission: a write starts it and the
  // line going idle after the last stop bit ends it.
  always_comb
  begin
    dir_next = dir_reg;
    unique case (dir_reg)
      DIR_IDLE:
      begin
        if (TX_LOAD)
        begin
          dir_next = DIR_SEND;
        end
      end
      DIR_SEND:
      begin
        if (TX_IDLE && !TX_LOAD)
        begin
          dir_next = DIR_IDLE;
        end
      end
      default:
      begin
        dir_next = DIR_IDLE;
      end
    endcase
  end

  // The transmitter owns the pin in auto-direction mode.
  always_comb
  begin
    if (auto_dir)
    begin
      rts_next = sending ^ rts_invert;
    end
    else if (HW_FLOW_EN)
    begin
      rts_next = FLOW_RTS_PIN;
    end
    else
    begin
      rts_next = !modem_control_reg[BIT_MODEM_RTS];
    end
  end

  // Hardware enable and disable are applied after the software write so
  // that an automatic enable is not lost to a clear in the same cycle.
  always_comb
  begin
    rx_en_next = rx_en_reg;
    if (wr_hit(OFS_RX_CTRL))
    begin
      rx_en_next = REG_WDATA[BIT_RX_ENABLE];
    end
    if (fif.en_clr)
    begin
      rx_en_next = 1'b0;
    end
    if (fif.en_set)
    begin
      rx_en_next = 1'b1;
    end
  end

  // Data ready clears on read, but a new character in that cycle wins.
  always_comb
  begin
    line_status_next = line_status_reg;
    if (rd_hit(OFS_LINE_STATUS))
    begin
      line_status_next[BIT_DATA_READY] = 1'b0;
    end
    if (fif.push)
    begin
      line_status_next[BIT_DATA_READY] = 1'b1;
      line_status_next[BIT_PARITY_ERR] = fif.push_perr;
    end
  end

  always_comb
  begin
    int_status_next = int_status_reg;
    if (wr_hit(OFS_INT_CLEAR))
    begin
      int_status_next = int_status_reg & ~REG_WDATA;
    end
    if (fif.push)
    begin
      int_status_next[BIT_EV_RX_DATA] = 1'b1;
    end
    if (fif.push && fif.push_perr)
    begin
      int_status_next[BIT_EV_LINE_STATUS] = 1'b1;
    end
    if (tx_done)
    begin
      int_status_next[BIT_EV_TX_DONE] = 1'b1;
    end
  end

  always_comb
  begin
    unique case (REG_ADDR)
      OFS_MODEM_CTRL: rdata_next = modem_control_reg;
      OFS_FEATURE_CTRL: rdata_next = feature_control_reg;
      OFS_RS485_CTRL: rdata_next = rs485_control_reg;
      OFS_ENH_FEATURE: rdata_next = enhanced_feature_reg;
      OFS_MATCH_CHAR: rdata_next = second_match_char_reg;
      OFS_LINE_CTRL: rdata_next = line_control_reg;
      OFS_INT_ENABLE: rdata_next = interrupt_enable_reg;
      OFS_LINE_STATUS: rdata_next = line_status_reg;
      OFS_RX_CTRL: rdata_next = {7'h00, rx_en_reg};
      OFS_INT_STATUS: rdata_next = int_status_reg;
      default: rdata_next = 8'h00;
    endcase
    if (!REG_RD)
    begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      modem_control_reg <= RST_REG;
      feature_control_reg <= RST_REG;
      rs485_control_reg <= RST_REG;
      enhanced_feature_reg <= RST_REG;
      second_match_char_reg <= RST_REG;
      line_control_reg <= RST_REG;
      interrupt_enable_reg <= RST_REG;
    end
    else
    begin
      if (wr_hit(OFS_MODEM_CTRL)) modem_control_reg <= REG_WDATA;
      if (wr_hit(OFS_FEATURE_CTRL)) feature_control_reg <= REG_WDATA;
      if (wr_hit(OFS_RS485_CTRL)) rs485_control_reg <= REG_WDATA;
      if (wr_hit(OFS_ENH_FEATURE)) enhanced_feature_reg <= REG_WDATA;
      if (wr_hit(OFS_MATCH_CHAR)) second_match_char_reg <= REG_WDATA;
      if (wr_hit(OFS_LINE_CTRL)) line_control_reg <= REG_WDATA;
      if (wr_hit(OFS_INT_ENABLE)) interrupt_enable_reg <= REG_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dir_reg <= DIR_IDLE;
      rx_en_reg <= 1'b0;
      line_status_reg <= RST_REG;
      int_status_reg <= RST_REG;
      RTS_PIN <= RST_RTS_PIN;
      IRQ <= 1'b0;
      REG_RDATA <= RST_REG;
    end
    else
    begin
      dir_reg <= dir_next;
      rx_en_reg <= rx_en_next;
      line_status_reg <= line_status_next;
      int_status_reg <= int_status_next;
      RTS_PIN <= rts_next;
      IRQ <= |irq_src;
      REG_RDATA <= rdata_next;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      FIFO_PUSH <= 1'b0;
      FIFO_DATA <= RST_REG;
      FIFO_PERR <= 1'b0;
    end
    else
    begin
      FIFO_PUSH <= fif.push;
      FIFO_DATA <= RX_DATA;
      FIFO_PERR <= fif.push_perr;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  // Spelled out rather than through the helper, because a continuous
  // assignment only wakes on the operands that it names.
  wire rx_ctl_wr = REG_WR && (REG_ADDR == OFS_RX_CTRL);
  wire int_clr_wr = REG_WR && (REG_ADDR == OFS_INT_CLEAR);

  sequence addr_match_s;
    multidrop && special && RX_VALID && RX_PARITY
      && (RX_DATA == second_match_char_reg);
  endsequence

  sequence stored_enabled_s;
    FIFO_PUSH && FIFO_PERR && rx_en_reg;
  endsequence

  sequence addr_miss_s;
    multidrop && special && RX_VALID && RX_PARITY
      && (RX_DATA != second_match_char_reg) && !rx_ctl_wr;
  endsequence

  AST_RTS_AUTO_HIGH: assert property (
    auto_dir && !rts_invert && TX_LOAD |=> RTS_PIN)
    else $error("Pin not high after transmit write.");

  AST_RTS_AUTO_INV: assert property (
    auto_dir && rts_invert && TX_LOAD |=> !RTS_PIN)
    else $error("Inverted pin not low after transmit write.");

  AST_RTS_RELEASE: assert property (
    auto_dir && !rts_invert && dir_reg == DIR_SEND && TX_IDLE && !TX_LOAD
      |=> !RTS_PIN)
    else $error("Pin not released after last bit.");

  AST_RTS_MANUAL: assert property (
    !auto_dir && !HW_FLOW_EN
      |=> RTS_PIN == !$past(modem_control_reg[BIT_MODEM_RTS]))
    else $error("Pin does not follow modem control.");

  AST_NORMAL_ADDR: assert property (
    multidrop && !special && RX_VALID && RX_PARITY |=> FIFO_PUSH && FIFO_PERR)
    else $error("Address not stored with parity error.");

  AST_DROP_DATA: assert property (
    multidrop && !rx_en_reg && RX_VALID && !RX_PARITY |=> !FIFO_PUSH)
    else $error("Data stored while receiver disabled.");

  AST_AUTO_MATCH: assert property (
    addr_match_s |=> stored_enabled_s)
    else $error("Matching address did not enable and store.");

  AST_AUTO_MISS: assert property (
    addr_miss_s |=> !FIFO_PUSH && !rx_en_reg)
    else $error("Mismatching address not dropped.");

  AST_PASS_THROUGH: assert property (
    !multidrop && RX_VALID |=> FIFO_PUSH && FIFO_PERR == $past(RX_PERR))
    else $error("Character lost outside multidrop.");

  AST_LS_IRQ: assert property (
    FIFO_PUSH && FIFO_PERR && interrupt_enable_reg[BIT_EV_LINE_STATUS]
      && $stable(interrupt_enable_reg) && !int_clr_wr |=> IRQ)
    else $error("Line status interrupt not raised.");
endmodule // rs485_ctrl

/* station_model.sv */
// Purpose: Serial engine and remote station stand-in.
// Assumes: One character per request, fixed transmit time.
// Notes: Idle receive lines toggle so stale values never look valid.
`timescale 1ns/1ps
module station_model #(parameter int TX_CYCLES = 10)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic [9:0] req_char,
  input wire logic tx_load,
  output logic rx_valid,
  output logic [9:0] rx_char,
  output logic tx_idle
);
  int cnt;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {rx_valid, rx_char, tx_idle} <= 12'h001;
      cnt <= 0;
    end
    else
    begin
      rx_valid <= req;
      rx_char <= req ? req_char : ~rx_char;
      cnt <= tx_load ? TX_CYCLES : (cnt > 0 ? cnt - 1 : 0);
      tx_idle <= !tx_load && cnt <= 1;
    end
  end
endmodule // station_model

/* tb.sv */
// Purpose: Bench for RS-485 direction and address logic.
// Assumes: One-cycle register and receive latencies.
// Notes: Random stimulus from a fixed-seed shift register.
`timescale 1ns/1ps
module tb;
  import rs485_pkg::*;
  logic clk = 1'b0;
  logic rst_b, wr, rd, flow_en, flow_rts, tx_load, req, tx_idle, rx_valid;
  logic rts, push, fperr, irq, md, au, en;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, fdata, rv, mc;
  logic [9:0] req_char, rx_char;
  logic [31:0] seed = 32'h980F;
  int errors = 0;
  int n_checks = 0;
  rs485_ctrl i_dut (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .HW_FLOW_EN(flow_en), .FLOW_RTS_PIN(flow_rts), .TX_LOAD(tx_load),
    .TX_IDLE(tx_idle), .RX_VALID(rx_valid), .RX_DATA(rx_char[7:0]),
    .RX_PARITY(rx_char[8]), .RX_PERR(rx_char[9]), .RTS_PIN(rts),
    .FIFO_PUSH(push), .FIFO_DATA(fdata), .FIFO_PERR(fperr), .IRQ(irq));
  station_model i_far (.clk(clk), .rst_b(rst_b), .req(req),
    .req_char(req_char), .tx_load(tx_load), .rx_valid(rx_valid),
    .rx_char(rx_char), .tx_idle(tx_idle));
  initial forever #2 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] exp_rx(input logic [9:0] c);
    if (!md) return {1'b1, c[9], en};
    if (!c[8]) return {en, 1'b0, en};
    if (!au) return {2'b11, en};
    return (c[7:0] === mc) ? 3'b111 : 3'b000;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1 rv = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [9:0] c);
    logic [2:0] e;
    e = exp_rx(c);
    @(posedge clk);
    req <= 1'b1;
    req_char <= c;
    @(posedge clk);
    req <= 1'b0;
    wait_cyc(1);
    chk("push", e[2], push);
    if (e[2])
    begin
      chk("data", c[7:0], fdata);
      chk("perr", e[1], fperr);
    end
    en = e[0];
  endtask
  task automatic rand_run(input int n);
    repeat (n)
    begin
      seed = lfsr(seed);
      send({!md && seed[10], seed[8], seed[9] ? mc : seed[7:0]});
    end
  endtask
  task automatic summarize(input int hang);
    errors += hang;
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    summarize(1);
  end
  initial
  begin
    {rst_b, wr, rd, flow_en, flow_rts, tx_load, req, md, au, en} = '0;
    {addr, wdata, req_char} = '0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    acc(1, OFS_LINE_STATUS, 8'hFF);
    chk("rts", RST_RTS_PIN, rts);
    for (int a = 0; a < 16; a++)
    begin
      acc(0, a[3:0], 8'h00);
      chk("reg", RST_REG, rv);
    end
    for (int i = 1; i >= 0; i--)
    begin
      acc(1, OFS_MODEM_CTRL, {6'h00, i[0], 1'b0});
      wait_cyc(2);
      chk("rts", !i[0], rts);
    end
    @(posedge clk);
    flow_en <= 1'b1;
    repeat (6)
    begin
      seed = lfsr(seed);
      @(posedge clk);
      flow_rts <= seed[0];
      wait_cyc(1);
      chk("rts", flow_rts, rts);
    end
    @(posedge clk);
    flow_en <= 1'b0;
    acc(1, OFS_FEATURE_CTRL, 8'h20);
    for (int i = 0; i < 2; i++)
    begin
      acc(1, OFS_INT_CLEAR, 8'hFF);
      acc(1, OFS_RS485_CTRL, {2'b00, i[0], 5'h00});
      wait_cyc(2);
      chk("rts", i[0], rts);
      @(posedge clk);
      tx_load <= 1'b1;
      @(posedge clk);
      tx_load <= 1'b0;
      wait_cyc(3);
      chk("rts", !i[0], rts);
      for (int k = 0; k < 50 && tx_idle !== 1'b1; k++)
        wait_cyc(1);
      if (tx_idle !== 1'b1)
        summarize(1);
      wait_cyc(2);
      chk("rts", i[0], rts);
      acc(0, OFS_INT_STATUS, 8'h00);
      chk("txd", 8'h02, rv & 8'h02);
    end
    acc(1, OFS_INT_ENABLE, 8'h04);
    acc(1, OFS_LINE_CTRL, 8'h38);
    acc(1, OFS_RS485_CTRL, 8'h01);
    md = 1'b1;
    send(10'h0A5);
    send(10'h15A);
    wait_cyc(1);
    chk("irq", 8'h01, irq);
    acc(0, OFS_LINE_STATUS, 8'h00);
    chk("ls", 8'h05, rv & 8'h05);
    acc(1, OFS_INT_CLEAR, 8'h04);
    wait_cyc(2);
    chk("irq", 8'h00, irq);
    acc(1, OFS_RX_CTRL, 8'h01);
    en = 1'b1;
    send(10'h033);
    acc(1, OFS_INT_ENABLE, 8'h00);
    send(10'h1C3);
    wait_cyc(1);
    chk("irq", 8'h00, irq);
    acc(1, OFS_RX_CTRL, 8'h00);
    en = 1'b0;
    seed = lfsr(seed);
    mc = seed[7:0];
    acc(1, OFS_MATCH_CHAR, mc);
    acc(0, OFS_MATCH_CHAR, 8'h00);
    chk("match", mc, rv);
    wait_cyc(1);
    chk("rdata", 8'h00, rdata);
    acc(1, OFS_ENH_FEATURE, 8'h20);
    au = 1'b1;
    send({2'b00, mc});
    send({2'b01, ~mc});
    send({2'b01, mc});
    acc(0, OFS_RX_CTRL, 8'h00);
    chk("rxen", 8'h01, rv);
    send({2'b01, mc});
    send({2'b01, ~mc});
    acc(0, OFS_RX_CTRL, 8'h00);
    chk("rxen", 8'h00, rv);
    rand_run(60);
    md = 1'b0;
    acc(1, OFS_RS485_CTRL, 8'h00);
    rand_run(40);
    summarize(0);
  end
endmodule // tb
